// ### src/secd_device.sv
// Purpose: instruction decoder, status and protection of a serial eeprom
// Assumes: sck clocks the link logic; clock runs the write timer
// Notes:   array data path is outside; array reads shift out zeros
// Functional notes
// - bytes msb first, first byte is opcode
// - unknown opcode waits until deselected
// - set-latch opcode sets latch, then waits
// - clear-latch opcode clears latch, then waits
// - latch clears on reset, clear, write completion
// - latch low rejects array and status writes
// - status read allowed anytime, even busy
// - status byte repeats while still selected
// - master polls busy flag before next command
// - busy flag high exactly during write cycle
// - opcode 03 is array read, two-byte address
// - opcode 02 is array write, address, data
// - address two bytes, high first, sixteen bits
// - id page opcodes, low seven address bits
// - lock status read uses address bit ten
// - page lock write uses address bit ten
// - protect bits change only by status write
// - protect bits frozen in hardware protected mode
// - lock bit with protect pin low rejects
// - protect codes map quarter, half, whole array
// - writes execute only on byte-aligned deselect
// - sample rising edge, drive falling edge
`timescale 1ns/1ps
module secd_device
	import secd_pkg::*;
#(
	parameter bit ID_VARIANT = 1'b1,
	parameter int WR_CYCLES  = WRITE_CYCLES
) (
	// system
	input  wire logic        clock,
	input  wire logic        rst,
	// link
	secd_if.dev              lnk,
	// array write request
	output logic             mem_wr_start,
	output logic             mem_wr_id,
	output logic [15:0]      mem_wr_addr,
	output logic [7:0]       mem_wr_data,
	// state
	output logic [7:0]       status_out,
	output logic             id_locked_out
);
	localparam int CW = $clog2(WR_CYCLES);
	if (WR_CYCLES < 2) $error("write cycle count too small");

	secd_lstate_t state_reg;
	secd_osel_t   osel_reg;
	logic [2:0]   bit_cnt_reg;
	logic [6:0]   sh_reg;
	logic [7:0]   opc_reg;
	logic [7:0]   addr_hi_reg;
	logic         addr_byte_reg;
	logic [7:0]   byte_in;
	logic         byte_done;
	logic [15:0]  addr_full;
	secd_cmd_t    pend_cmd_reg;
	logic [15:0]  pend_addr_reg;
	logic [7:0]   pend_data_reg;
	logic         pend_aligned_reg;
	logic [7:0]   stat_s1_reg, stat_s2_reg;
	logic         lock_s1_reg, lock_s2_reg;
	logic [6:0]   out_sh_reg;
	logic         miso_reg, oe_n_reg;
	logic [7:0]   out_byte;

	assign byte_in   = {sh_reg, lnk.mosi};
	assign byte_done = (bit_cnt_reg == 3'h7);
	assign addr_full = {addr_hi_reg, byte_in};

	// frame logic, cleared by deselection itself since sck may stop
	always_ff @(posedge lnk.sck or posedge lnk.cs_n) begin
		if (lnk.cs_n) begin
			state_reg     <= L_OPC;
			osel_reg      <= O_STATUS;
			bit_cnt_reg   <= 3'h0;
			sh_reg        <= 7'h00;
			opc_reg       <= 8'h00;
			addr_hi_reg   <= 8'h00;
			addr_byte_reg <= 1'b0;
		end else begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			sh_reg      <= byte_in[6:0];
			if (byte_done) begin
				unique case (state_reg)
					L_OPC: begin
						opc_reg <= byte_in;
						unique case (byte_in)
							SET_WRITE_LATCH_CMD:   state_reg <= L_WAIT;
							CLEAR_WRITE_LATCH_CMD: state_reg <= L_WAIT;
							STATUS_READ_CMD: begin
								state_reg <= L_OUT;
								osel_reg  <= O_STATUS;
							end
							STATUS_WRITE_CMD: state_reg <= L_DATA;
							MEM_READ_CMD:     state_reg <= L_ADDR;
							MEM_WRITE_CMD:    state_reg <= L_ADDR;
							ID_PAGE_READ_CMD, ID_PAGE_WRITE_CMD:
								state_reg <= ID_VARIANT ? L_ADDR : L_WAIT;
							default: state_reg <= L_WAIT;
						endcase
					end
					L_ADDR: begin
						addr_byte_reg <= 1'b1;
						if (!addr_byte_reg) begin
							addr_hi_reg <= byte_in;
						end else if (opc_reg == MEM_READ_CMD) begin
							state_reg <= L_OUT;
							osel_reg  <= O_ARRAY;
						end else if (opc_reg == ID_PAGE_READ_CMD) begin
							if (addr_full == ID_LOCK_ADDR) begin
								state_reg <= L_OUT;
								osel_reg  <= O_LOCK;
							end else if ((addr_full & ID_ADDR_UPPER) == 16'h0000) begin
								state_reg <= L_OUT;
								osel_reg  <= O_ARRAY;
							end else begin
								state_reg <= L_WAIT;
							end
						end else begin
							state_reg <= L_DATA;
						end
					end
					L_DATA: state_reg <= L_DATA;
					L_OUT:  state_reg <= L_OUT;
					L_WAIT: state_reg <= L_WAIT;
					default: state_reg <= L_WAIT;
				endcase
			end
		end
	end

	// pending command survives deselection for the system side to read
	always_ff @(posedge lnk.sck or posedge rst) begin
		if (rst) begin
			pend_cmd_reg     <= C_NONE;
			pend_addr_reg    <= 16'h0000;
			pend_data_reg    <= 8'h00;
			pend_aligned_reg <= 1'b0;
		end else if (!lnk.cs_n) begin
			pend_aligned_reg <= byte_done;
			if (state_reg == L_OPC && bit_cnt_reg == 3'h0) begin
				pend_cmd_reg <= C_NONE;
			end
			if (byte_done) begin
				if (state_reg == L_OPC) begin
					if (byte_in == SET_WRITE_LATCH_CMD) begin
						pend_cmd_reg <= C_SET_LATCH;
					end else if (byte_in == CLEAR_WRITE_LATCH_CMD) begin
						pend_cmd_reg <= C_CLR_LATCH;
					end
				end else if (state_reg == L_ADDR && addr_byte_reg) begin
					pend_addr_reg <= addr_full;
				end else if (state_reg == L_DATA) begin
					pend_data_reg <= byte_in;
					if (opc_reg == STATUS_WRITE_CMD) begin
						pend_cmd_reg <= C_STAT_WR;
					end else if (opc_reg == MEM_WRITE_CMD) begin
						pend_cmd_reg <= C_WRITE;
					end else if (pend_addr_reg == ID_LOCK_ADDR) begin
						pend_cmd_reg <= C_LOCK;
					end else begin
						pend_cmd_reg <= C_ID_WR;
					end
				end
			end
		end
	end

	// status snapshot into the link domain
	always_ff @(posedge lnk.sck or posedge rst) begin
		if (rst) begin
			stat_s1_reg <= STATUS_RST;
			stat_s2_reg <= STATUS_RST;
			lock_s1_reg <= 1'b0;
			lock_s2_reg <= 1'b0;
		end else begin
			stat_s1_reg <= status_out;
			stat_s2_reg <= stat_s1_reg;
			lock_s1_reg <= id_locked_out;
			lock_s2_reg <= lock_s1_reg;
		end
	end

	always_comb begin
		unique case (osel_reg)
			O_STATUS: out_byte = stat_s2_reg;
			O_LOCK:   out_byte = {7'h00, lock_s2_reg};
			O_ARRAY:  out_byte = 8'h00;
			default:  out_byte = 8'h00;
		endcase
	end

	// output shifts on falling edge; reload at each byte start
	always_ff @(negedge lnk.sck or posedge lnk.cs_n) begin
		if (lnk.cs_n) begin
			out_sh_reg <= 7'h00;
			miso_reg   <= 1'b0;
			oe_n_reg   <= 1'b1;
		end else if (state_reg == L_OUT) begin
			oe_n_reg <= 1'b0;
			if (bit_cnt_reg == 3'h0) begin
				miso_reg   <= out_byte[7];
				out_sh_reg <= out_byte[6:0];
			end else begin
				miso_reg   <= out_sh_reg[6];
				out_sh_reg <= {out_sh_reg[5:0], 1'b0};
			end
		end else begin
			oe_n_reg <= 1'b1;
			miso_reg <= 1'b0;
		end
	end
	assign lnk.miso      = miso_reg;
	assign lnk.miso_oe_n = oe_n_reg;

	// system domain
	logic          cs_s1_reg, cs_s2_reg, cs_s3_reg;
	logic          wp_s1_reg, wp_s2_reg;
	logic          wr_latch_reg, busy_reg, st_lock_reg, idl_reg;
	logic [1:0]    bp_reg;
	logic [7:0]    new_stat_reg;
	secd_cmd_t     job_reg;
	logic [CW-1:0] cnt_reg;
	logic          deselect, hw_prot, prot_hit;

	always_ff @(posedge clock) begin
		if (rst) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			cs_s3_reg <= 1'b1;
			wp_s1_reg <= 1'b1;
			wp_s2_reg <= 1'b1;
		end else begin
			cs_s1_reg <= lnk.cs_n;
			cs_s2_reg <= cs_s1_reg;
			cs_s3_reg <= cs_s2_reg;
			wp_s1_reg <= lnk.wp_n;
			wp_s2_reg <= wp_s1_reg;
		end
	end

	assign deselect = cs_s2_reg & ~cs_s3_reg;
	assign hw_prot  = st_lock_reg & ~wp_s2_reg;
	always_comb begin
		unique case (bp_reg)
			BP_NONE:    prot_hit = 1'b0;
			BP_QUARTER: prot_hit = pend_addr_reg >= PROT_QUARTER;
			BP_HALF:    prot_hit = pend_addr_reg >= PROT_HALF;
			default:    prot_hit = 1'b1;
		endcase
	end

	// pending fields are quiet here: sck idles while deselected
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_latch_reg <= 1'b0;
			busy_reg     <= 1'b0;
			st_lock_reg  <= 1'b0;
			bp_reg       <= 2'h0;
			idl_reg      <= 1'b0;
			new_stat_reg <= STATUS_RST;
			job_reg      <= C_NONE;
			cnt_reg      <= '0;
			mem_wr_start <= 1'b0;
			mem_wr_id    <= 1'b0;
			mem_wr_addr  <= 16'h0000;
			mem_wr_data  <= 8'h00;
		end else begin
			mem_wr_start <= 1'b0;
			if (busy_reg) begin
				cnt_reg <= cnt_reg + CW'(1);
				if (cnt_reg == CW'(WR_CYCLES - 1)) begin
					busy_reg <= 1'b0;
					wr_latch_reg <= 1'b0;
					if (job_reg == C_STAT_WR) begin
						st_lock_reg <= new_stat_reg[STATUS_LOCK_POS];
						bp_reg   <= {new_stat_reg[BP_HI_POS],
							new_stat_reg[BP_LO_POS]};
					end
					if (job_reg == C_LOCK) begin
						idl_reg <= 1'b1;
					end
				end
			end else if (deselect && pend_aligned_reg) begin
				job_reg      <= pend_cmd_reg;
				new_stat_reg <= pend_data_reg;
				cnt_reg      <= '0;
				mem_wr_addr  <= pend_addr_reg;
				mem_wr_data  <= pend_data_reg;
				mem_wr_id    <= (pend_cmd_reg == C_ID_WR);
				unique case (pend_cmd_reg)
					C_SET_LATCH: wr_latch_reg <= 1'b1;
					C_CLR_LATCH: wr_latch_reg <= 1'b0;
					C_STAT_WR:
						busy_reg <= wr_latch_reg & ~hw_prot;
					C_WRITE: begin
						busy_reg     <= wr_latch_reg & ~prot_hit;
						mem_wr_start <= wr_latch_reg & ~prot_hit;
					end
					C_ID_WR: begin
						busy_reg     <= wr_latch_reg & ~idl_reg &
							((pend_addr_reg & ID_ADDR_UPPER) == 16'h0000);
						mem_wr_start <= wr_latch_reg & ~idl_reg &
							((pend_addr_reg & ID_ADDR_UPPER) == 16'h0000);
					end
					C_LOCK: busy_reg <= wr_latch_reg & ~idl_reg;
					default: busy_reg <= 1'b0;
				endcase
			end
		end
	end

	// status byte, unused bits zero
	always_ff @(posedge clock) begin
		if (rst) begin
			status_out    <= STATUS_RST;
			id_locked_out <= 1'b0;
		end else begin
			status_out <= STATUS_RST;
			status_out[STATUS_LOCK_POS] <= st_lock_reg;
			status_out[BP_HI_POS]       <= bp_reg[1];
			status_out[BP_LO_POS]       <= bp_reg[0];
			status_out[LATCH_POS]       <= wr_latch_reg;
			status_out[BUSY_POS]        <= busy_reg;
			id_locked_out               <= idl_reg;
		end
	end
endmodule

// ### src/secd_host.sv
// Purpose: serial master end; frames bytes out and in, mode zero
// Assumes: user streams bytes with last marking the final one
// Notes:   sck is divided from clock; half period HALF clock cycles
`timescale 1ns/1ps
module secd_host
	import secd_pkg::*;
#(
	parameter int HALF = HOST_HALF_DEF
) (
	// system
	input  wire logic       clock,
	input  wire logic       rst,
	// link
	secd_if.host            lnk,
	// byte stream in
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_last,
	output logic            tx_ready,
	// byte stream out
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	// protect pin level
	input  wire logic       wp_n_in
);
	localparam int DW = $clog2(HALF + 1);
	// miso must settle through its synchroniser inside one half period
	if (HALF < 3) $error("half period too short for miso sync");

	secd_hstate_t  state_reg;
	logic [DW-1:0] div_reg;
	logic [2:0]    bit_reg;
	logic [7:0]    tx_sh_reg, rx_sh_reg;
	logic          last_reg, sck_reg, cs_n_reg, mosi_reg, wp_reg;
	logic          miso_s1_reg, miso_s2_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			miso_s1_reg <= 1'b0;
			miso_s2_reg <= 1'b0;
			wp_reg      <= 1'b1;
		end else begin
			miso_s1_reg <= lnk.miso;
			miso_s2_reg <= miso_s1_reg;
			wp_reg      <= wp_n_in;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= H_IDLE;
			div_reg   <= '0;
			bit_reg   <= 3'h0;
			tx_sh_reg <= 8'h00;
			rx_sh_reg <= 8'h00;
			last_reg  <= 1'b0;
			sck_reg   <= 1'b0;
			cs_n_reg  <= 1'b1;
			mosi_reg  <= 1'b0;
			tx_ready  <= 1'b1;
			rx_valid  <= 1'b0;
			rx_data   <= 8'h00;
		end else begin
			rx_valid <= 1'b0;
			unique case (state_reg)
				H_IDLE, H_LOAD: begin
					if (tx_valid) begin
						tx_sh_reg <= tx_data;
						mosi_reg  <= tx_data[7];
						last_reg  <= tx_last;
						cs_n_reg  <= 1'b0;
						tx_ready  <= 1'b0;
						div_reg   <= '0;
						bit_reg   <= 3'h0;
						state_reg <= H_SHIFT;
					end
				end
				H_SHIFT: begin
					div_reg <= div_reg + DW'(1);
					if (div_reg == DW'(HALF - 1)) begin
						div_reg <= '0;
						sck_reg <= ~sck_reg;
						if (!sck_reg) begin
							rx_sh_reg <= {rx_sh_reg[6:0], miso_s2_reg};
						end else if (bit_reg == 3'h7) begin
							rx_valid <= 1'b1;
							rx_data  <= rx_sh_reg;
							if (last_reg) begin
								state_reg <= H_END;
							end else begin
								state_reg <= H_LOAD;
								tx_ready  <= 1'b1;
							end
						end else begin
							bit_reg   <= bit_reg + 3'h1;
							mosi_reg  <= tx_sh_reg[6];
							tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
						end
					end
				end
				H_END: begin
					div_reg <= div_reg + DW'(1);
					if (div_reg == DW'(HALF - 1)) begin
						div_reg <= '0;
						if (!cs_n_reg) begin
							cs_n_reg <= 1'b1;
						end else begin
							state_reg <= H_IDLE;
							tx_ready  <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	assign lnk.sck  = sck_reg;
	assign lnk.cs_n = cs_n_reg;
	assign lnk.mosi = mosi_reg;
	assign lnk.wp_n = wp_reg;
endmodule

// ### src/secd_if.sv
// Purpose: serial link pins between master and eeprom decoder
// Assumes: single master, one device
// Notes:   miso carries an enable; nothing resolves the wire, the checker only watches it
`timescale 1ns/1ps
interface secd_if;
	logic sck;
	logic cs_n;
	logic mosi;
	logic miso;
	logic miso_oe_n;
	logic wp_n;
	modport dev (input sck, input cs_n, input mosi, input wp_n,
		output miso, output miso_oe_n);
	modport host (output sck, output cs_n, output mosi, output wp_n,
		input miso, input miso_oe_n);
endinterface

// ### src/secd_pkg.sv
// Purpose: shared constants and types for the serial eeprom command decoder
// Assumes: both ends and the bench import this package
// Notes:   opcodes, status layout, protection bounds, timing counts
package secd_pkg;
	// opcodes
	localparam logic [7:0] SET_WRITE_LATCH_CMD   = 8'h06;
	localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
	localparam logic [7:0] STATUS_READ_CMD       = 8'h05;
	localparam logic [7:0] STATUS_WRITE_CMD      = 8'h01;
	localparam logic [7:0] MEM_READ_CMD          = 8'h03;
	localparam logic [7:0] MEM_WRITE_CMD         = 8'h02;
	localparam logic [7:0] ID_PAGE_READ_CMD      = 8'h83;
	localparam logic [7:0] ID_PAGE_WRITE_CMD     = 8'h82;
	// status_control_byte field positions
	localparam int STATUS_LOCK_POS  = 7;
	localparam int BP_HI_POS        = 3;
	localparam int BP_LO_POS        = 2;
	localparam int LATCH_POS        = 1;
	localparam int BUSY_POS         = 0;
	localparam logic [7:0] STATUS_RST = 8'h00;
	// address qualifiers and protect codes
	localparam logic [15:0] ID_LOCK_ADDR  = 16'h0400;
	localparam logic [15:0] ID_ADDR_UPPER = 16'hff80;
	localparam logic [15:0] PROT_QUARTER  = 16'hc000;
	localparam logic [15:0] PROT_HALF     = 16'h8000;
	localparam logic [1:0]  BP_NONE       = 2'h0;
	localparam logic [1:0]  BP_QUARTER    = 2'h1;
	localparam logic [1:0]  BP_HALF       = 2'h2;
	// timing
	localparam int CLK_HZ         = 40_000_000;
	localparam int T_WRITE_MS     = 5;
	localparam int WRITE_CYCLES   = T_WRITE_MS * (CLK_HZ / 1000);
	localparam int HOST_HALF_DEF  = 4;
	// link-side decoder states, gray along opcode-address-data
	typedef enum logic [2:0] {
		L_OPC  = 3'h0,
		L_ADDR = 3'h1,
		L_DATA = 3'h3,
		L_OUT  = 3'h2,
		L_WAIT = 3'h6
	} secd_lstate_t;
	typedef enum logic [1:0] {
		O_STATUS = 2'h0,
		O_LOCK   = 2'h1,
		O_ARRAY  = 2'h2
	} secd_osel_t;
	// command left pending for execution at deselection
	typedef enum logic [2:0] {
		C_NONE      = 3'h0,
		C_SET_LATCH = 3'h1,
		C_CLR_LATCH = 3'h2,
		C_STAT_WR   = 3'h3,
		C_WRITE     = 3'h4,
		C_ID_WR     = 3'h5,
		C_LOCK      = 3'h6
	} secd_cmd_t;
	typedef enum logic [1:0] {
		H_IDLE  = 2'h0,
		H_LOAD  = 2'h1,
		H_SHIFT = 2'h3,
		H_END   = 2'h2
	} secd_hstate_t;
endpackage

// ### tb/secd_chk.sv
// Purpose: link-level checks between serial master and eeprom decoder
// Assumes: host HALF of 4, mode zero, all sampled on the system clock
// Notes:   sck phases are counted in clocks since sck is divided
`timescale 1ns/1ps
module secd_chk (
	// system
	input wire logic clock,
	input wire logic rst,
	// link
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe_n,
	input wire logic wp_n
);
	logic [7:0] bits_reg;
	logic       sck_q_reg;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	always_ff @(posedge clock) begin
		sck_q_reg <= sck;
	end
	// rising sck edges in this frame; saturates so long reads cannot wrap
	always_ff @(posedge clock) begin
		if (rst || cs_n) begin
			bits_reg <= 8'h00;
		end else if (sck && !sck_q_reg && bits_reg != 8'hff) begin
			bits_reg <= bits_reg + 8'h01;
		end
	end
	sequence sck_high_phase;
		sck [*4] ##1 !sck;
	endsequence
	sequence lead_in;
		!sck [*4] ##1 sck;
	endsequence
	AST_SCK_IDLE: assert property (cs_n |-> !sck)
		else $error("sck not idle low");
	AST_SCK_HIGH: assert property ($rose(sck) |-> sck_high_phase)
		else $error("sck high phase wrong");
	AST_FRAME_START: assert property ($fell(cs_n) |-> lead_in)
		else $error("frame lead-in wrong");
	AST_MOSI_HOLD: assert property (sck && $past(sck) |-> $stable(mosi))
		else $error("mosi moved while sck high");
	AST_CS_ALIGN: assert property ($rose(cs_n) |-> bits_reg[2:0] == 3'h0)
		else $error("deselect off byte boundary");
	AST_OE_IDLE: assert property (cs_n |-> miso_oe_n)
		else $error("miso driven while deselected");
	AST_OE_START: assert property ($fell(miso_oe_n) |->
		(bits_reg == 8'h08 || bits_reg == 8'h18))
		else $error("output started at wrong bit");
	AST_OE_HOLD: assert property (!cs_n && !$past(miso_oe_n) |-> !miso_oe_n)
		else $error("output dropped in frame");
	AST_MISO_FALL: assert property (!miso_oe_n && !$past(miso_oe_n) &&
		$changed(miso) |-> $fell(sck))
		else $error("miso changed off falling edge");
	AST_WP_STEADY: assert property (!cs_n && !$past(cs_n) |-> $stable(wp_n))
		else $error("protect pin moved in frame");
endmodule

// ### tb/spi_eeprom_command_decoder_tb.sv
// Purpose: frames commands through the host end into the device end
// Assumes: WR_CYCLES shortened to 400 so busy outlasts a short frame
// Notes:   array data path is outside; reads return zero bytes
`timescale 1ns/1ps
module spi_eeprom_command_decoder_tb;
	import secd_pkg::*;
	localparam int TB_WR = 400;
	logic        clock;
	logic        rst;
	logic        tx_valid;
	logic [7:0]  tx_data;
	logic        tx_last;
	logic        tx_ready;
	logic        rx_valid;
	logic [7:0]  rx_data;
	logic        wp_n_in;
	logic        mem_wr_start;
	logic        mem_wr_id;
	logic [15:0] mem_wr_addr;
	logic [7:0]  mem_wr_data;
	logic [7:0]  status_out;
	logic        id_locked_out;
	logic [7:0]  rb [4];
	logic [15:0] wa;
	logic [7:0]  wd;
	logic        wid;
	logic [15:0] addrs [4];
	logic        prot;
	int          n_errors;
	int          checks_done;
	int          n_wr;
	int          w0;
	int          cycles;
	int          busy_len;
	secd_if lnk_if ();
	secd_host #(.HALF(4)) secd_host_i (.clock(clock), .rst(rst),
		.lnk(lnk_if), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid),
		.rx_data(rx_data), .wp_n_in(wp_n_in));
	secd_device #(.ID_VARIANT(1'b1), .WR_CYCLES(TB_WR)) secd_device_i (
		.clock(clock), .rst(rst), .lnk(lnk_if),
		.mem_wr_start(mem_wr_start), .mem_wr_id(mem_wr_id),
		.mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
		.status_out(status_out), .id_locked_out(id_locked_out));
	secd_chk secd_chk_i (.clock(clock), .rst(rst), .sck(lnk_if.sck),
		.cs_n(lnk_if.cs_n), .mosi(lnk_if.mosi), .miso(lnk_if.miso),
		.miso_oe_n(lnk_if.miso_oe_n), .wp_n(lnk_if.wp_n));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// the start pulse lasts one clock, so capture what it qualifies
	always @(posedge clock) begin
		cycles++;
		if (status_out[BUSY_POS] === 1'b1) begin
			busy_len++;
		end
		if (mem_wr_start === 1'b1) begin
			n_wr++;
			wa = mem_wr_addr;
			wd = mem_wr_data;
			wid = mem_wr_id;
		end
		if (cycles == 60000) begin
			n_errors++;
			$display("[FAIL] %0t timeout", $time);
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// one frame of n bytes; bytes read back land in rb
	task automatic xfer(input logic [7:0] b0, input logic [7:0] b1,
		input logic [7:0] b2, input logic [7:0] b3, input int n);
		logic [7:0] bs [4];
		bs = '{b0, b1, b2, b3};
		for (int i = 0; i < n; i++) begin
			tx_data = bs[i];
			tx_last = (i == n - 1);
			tx_valid = 1'b1;
			@(posedge clock);
			while (tx_ready !== 1'b1) @(posedge clock);
			#1;
			tx_valid = 1'b0;
			@(posedge clock);
			while (rx_valid !== 1'b1) @(posedge clock);
			rb[i] = rx_data;
			#1;
		end
		while (tx_ready !== 1'b1) @(posedge clock);
		#1;
	endtask
	// execution lands a few clocks after deselect; then wait out busy
	task automatic settle();
		repeat (8) @(posedge clock);
		while (status_out[BUSY_POS] !== 1'b0) @(posedge clock);
		#1;
	endtask
	task automatic wr_en();
		xfer(SET_WRITE_LATCH_CMD, 8'h00, 8'h00, 8'h00, 1);
		settle();
	endtask
	task automatic set_status(input logic [7:0] v);
		wr_en();
		xfer(STATUS_WRITE_CMD, v, 8'h00, 8'h00, 2);
		settle();
	endtask
	initial begin
		rst = 1'b1;
		tx_valid = 1'b0;
		tx_data = 8'h00;
		tx_last = 1'b0;
		wp_n_in = 1'b1;
		n_errors = 0;
		checks_done = 0;
		n_wr = 0;
		cycles = 0;
		addrs = '{16'h7fff, 16'h8000, 16'hbfff, 16'hc000};
		repeat (6) @(posedge clock);
		#1;
		rst = 1'b0;
		chk8(status_out, STATUS_RST, "reset status");
		chk8({7'h0, lnk_if.miso_oe_n}, 8'h01, "oe idle");
		$display("test reset done");
		xfer(STATUS_WRITE_CMD, 8'h8c, 8'h00, 8'h00, 2);
		settle();
		chk8(status_out, 8'h00, "write without latch");
		xfer(8'h5a, SET_WRITE_LATCH_CMD, 8'h00, 8'h00, 2);
		settle();
		chk8(status_out, 8'h00, "unknown opcode");
		wr_en();
		chk8(status_out, 8'h02, "latch set");
		xfer(STATUS_READ_CMD, 8'h00, 8'h00, 8'h00, 4);
		chk8(rb[1], 8'h02, "status read");
		chk8(rb[3], 8'h02, "status repeat");
		xfer(CLEAR_WRITE_LATCH_CMD, 8'h00, 8'h00, 8'h00, 1);
		settle();
		chk8(status_out, 8'h00, "latch clear");
		$display("test latch done");
		wr_en();
		busy_len = 0;
		xfer(STATUS_WRITE_CMD, 8'h8c, 8'h00, 8'h00, 2);
		xfer(STATUS_READ_CMD, 8'h00, 8'h00, 8'h00, 2);
		chk8(rb[1], 8'h03, "busy read");
		settle();
		chk8(status_out, 8'h8c, "status written");
		chk8({7'h0, busy_len == TB_WR}, 8'h01, "busy length");
		wp_n_in = 1'b0;
		set_status(8'h00);
		chk8(status_out, 8'h8e, "locked status");
		wp_n_in = 1'b1;
		xfer(STATUS_WRITE_CMD, 8'h00, 8'h00, 8'h00, 2);
		settle();
		chk8(status_out, 8'h00, "unlocked status");
		$display("test status done");
		for (int bp = 0; bp < 4; bp++) begin
			set_status({4'h0, bp[1:0], 2'h0});
			for (int j = 0; j < 4; j++) begin
				wr_en();
				w0 = n_wr;
				xfer(MEM_WRITE_CMD, addrs[j][15:8], addrs[j][7:0], 8'h3c, 4);
				settle();
				prot = (bp == 3) || (bp == 2 && addrs[j] >= PROT_HALF) ||
					(bp == 1 && addrs[j] >= PROT_QUARTER);
				chk8(8'(n_wr - w0), {7'h0, !prot}, "array write");
				chk8(status_out, {4'h0, bp[1:0], prot, 1'b0}, "latch");
				if (!prot) begin
					chk8(wa[15:8], addrs[j][15:8], "addr hi");
					chk8(wa[7:0], addrs[j][7:0], "addr lo");
					chk8(wd, 8'h3c, "data");
				end
			end
		end
		set_status(8'h00);
		$display("test protect done");
		wr_en();
		xfer(ID_PAGE_WRITE_CMD, 8'h00, 8'h05, 8'haa, 4);
		settle();
		chk8({wid, wa[6:0]}, 8'h85, "id write");
		chk8(wd, 8'haa, "id data");
		xfer(ID_PAGE_READ_CMD, 8'h00, 8'h05, 8'h00, 4);
		chk8(rb[3], 8'h00, "id read");
		xfer(ID_PAGE_READ_CMD, 8'h04, 8'h00, 8'h00, 4);
		chk8(rb[3], 8'h00, "lock status clear");
		w0 = n_wr;
		wr_en();
		xfer(ID_PAGE_WRITE_CMD, 8'h01, 8'h05, 8'haa, 4);
		settle();
		chk8(8'(n_wr - w0), 8'h00, "bad id addr");
		wr_en();
		xfer(ID_PAGE_WRITE_CMD, 8'h04, 8'h00, 8'h00, 4);
		settle();
		chk8({7'h0, id_locked_out}, 8'h01, "id lock");
		xfer(ID_PAGE_READ_CMD, 8'h04, 8'h00, 8'h00, 4);
		chk8(rb[3], 8'h01, "lock status");
		w0 = n_wr;
		wr_en();
		xfer(ID_PAGE_WRITE_CMD, 8'h00, 8'h05, 8'haa, 4);
		settle();
		chk8(8'(n_wr - w0), 8'h00, "locked id write");
		xfer(MEM_READ_CMD, 8'h00, 8'h10, 8'h00, 4);
		chk8(rb[3], 8'h00, "array read");
		$display("test id done");
		test_done();
	end
endmodule
